//--- design/ilc_top.v
`include "ilc_defines.vh"

module ilc_top #(
   parameter MEAS_CYCLES = `ILC_MEAS_CYCLES,
   parameter ERR_LIMIT = `ILC_ERR_LIMIT,
   parameter GOOD_PERIODS = `ILC_GOOD_PERIODS
)(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr,
   input wire tx_bit_valid,
   input wire tx_bit_fbit,
   input wire tx_bit_in,
   output reg tx_out_valid,
   output reg tx_out_fbit,
   output reg tx_out_bit,
   input wire rx_bit_valid,
   input wire rx_bit_fbit,
   input wire rx_bit_in,
   output wire irq
);
   localparam integer MEAS_LAST_I = MEAS_CYCLES - 1;
   localparam [23:0] MEAS_LAST = MEAS_LAST_I[23:0];

   reg [7:0] send_control;
   reg [7:0] send_code_value;
   reg [7:0] detector_config;
   reg [7:0] up_code_value;
   reg [7:0] down_code_value;
   reg [7:0] detector_irq_enable;
   reg [1:0] detector_irq_flags;
   reg [1:0] present_d;
   reg [23:0] meas_count;
   reg period_end;
   reg [2:0] send_phase;

   wire [9:0] reg_idx;
   wire mapped;
   wire setup;
   wire wr_access;
   wire [1:0] present_now;
   wire [1:0] change;
   wire up_code_present;
   wire down_code_present;
   wire [1:0] send_length_select;
   wire send_unframed;
   wire send_code_enable;
   wire framing_bit_skip;
   wire [1:0] up_length_select;
   wire [1:0] down_length_select;
   wire [3:0] send_len;
   wire send_bit;
   wire overwrite;

   assign reg_idx = paddr[11:2];
   assign mapped = (paddr[1:0] == 2'h0)
                   && (reg_idx >= `ILC_IDX_SEND_CTRL)
                   && (reg_idx <= `ILC_IDX_IRQ_FLAGS);
   assign setup = psel & ~penable;
   // Zero wait state: every access completes in its first access cycle
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~mapped;
   assign wr_access = psel & penable & pwrite & mapped;

   assign send_length_select = send_control[`ILC_SEND_LEN_LSB +: 2];
   assign send_unframed = send_control[`ILC_SEND_UNFRAMED_BIT];
   assign send_code_enable = send_control[`ILC_SEND_ENABLE_BIT];
   assign framing_bit_skip = detector_config[`ILC_FBIT_SKIP_BIT];
   assign up_length_select = detector_config[`ILC_UP_SEL_LSB +: 2];
   assign down_length_select = detector_config[`ILC_DOWN_SEL_LSB +: 2];

   // Register writes
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         send_control <= `ILC_RST_SEND_CTRL;
         send_code_value <= `ILC_RST_SEND_CODE;
         detector_config <= `ILC_RST_DET_CFG;
         up_code_value <= `ILC_RST_UP_CODE;
         down_code_value <= `ILC_RST_DOWN_CODE;
         detector_irq_enable <= `ILC_RST_IRQ_EN;
      end
      else if (wr_access)
      begin
         case (reg_idx)
            `ILC_IDX_SEND_CTRL:
               send_control <= {4'h0, pwdata[3:0]};
            `ILC_IDX_SEND_CODE:
               send_code_value <= pwdata[7:0];
            `ILC_IDX_DET_CFG:
               detector_config <= {3'h0, pwdata[4:0]};
            `ILC_IDX_UP_CODE:
               up_code_value <= pwdata[7:0];
            `ILC_IDX_DOWN_CODE:
               down_code_value <= pwdata[7:0];
            `ILC_IDX_IRQ_EN:
               detector_irq_enable <= {6'h00, pwdata[1:0]};
            default:
               detector_irq_enable <= detector_irq_enable;
         endcase
      end
   end

   // Read data is captured in the setup cycle so it is a flop output
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (setup)
      begin
         case (reg_idx)
            `ILC_IDX_SEND_CTRL:
               prdata <= {24'h000000, send_control};
            `ILC_IDX_SEND_CODE:
               prdata <= {24'h000000, send_code_value};
            `ILC_IDX_DET_CFG:
               prdata <= {24'h000000, detector_config};
            `ILC_IDX_DET_STATE:
               prdata <= {30'h00000000, present_now};
            `ILC_IDX_UP_CODE:
               prdata <= {24'h000000, up_code_value};
            `ILC_IDX_DOWN_CODE:
               prdata <= {24'h000000, down_code_value};
            `ILC_IDX_IRQ_EN:
               prdata <= {24'h000000, detector_irq_enable};
            `ILC_IDX_IRQ_FLAGS:
               prdata <= {30'h00000000, detector_irq_flags};
            default:
               prdata <= 32'h00000000;
         endcase
      end
   end

   // Fixed measurement period, free running from reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meas_count <= 24'h000000;
         period_end <= 1'b0;
      end
      else
      begin
         period_end <= (meas_count == MEAS_LAST);
         if (meas_count == MEAS_LAST)
            meas_count <= 24'h000000;
         else
            meas_count <= meas_count + 24'h000001;
      end
   end

   ilc_matcher #(
      .ERR_LIMIT(ERR_LIMIT),
      .GOOD_PERIODS(GOOD_PERIODS)
   ) u_up_match (
      .pclk(pclk),
      .presetn(presetn),
      .bit_valid(rx_bit_valid),
      .bit_value(rx_bit_in),
      .bit_is_fbit(rx_bit_fbit),
      .skip_fbit(framing_bit_skip),
      .code_bits(up_code_value),
      .length_select(up_length_select),
      .period_end(period_end),
      .present(up_code_present)
   );

   ilc_matcher #(
      .ERR_LIMIT(ERR_LIMIT),
      .GOOD_PERIODS(GOOD_PERIODS)
   ) u_down_match (
      .pclk(pclk),
      .presetn(presetn),
      .bit_valid(rx_bit_valid),
      .bit_value(rx_bit_in),
      .bit_is_fbit(rx_bit_fbit),
      .skip_fbit(framing_bit_skip),
      .code_bits(down_code_value),
      .length_select(down_length_select),
      .period_end(period_end),
      .present(down_code_present)
   );

   assign present_now[`ILC_DOWN_BIT] = down_code_present;
   assign present_now[`ILC_UP_BIT] = up_code_present;
   assign change = present_now ^ present_d;

   // Hardware set wins over a clear written in the same cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         present_d <= 2'h0;
         detector_irq_flags <= 2'h0;
      end
      else
      begin
         present_d <= present_now;
         if (wr_access && reg_idx == `ILC_IDX_IRQ_FLAGS)
            detector_irq_flags <= (detector_irq_flags & ~pwdata[1:0])
                                  | change;
         else
            detector_irq_flags <= detector_irq_flags | change;
      end
   end

   assign irq = |(detector_irq_flags & detector_irq_enable[1:0]);

   // Transmit insertion
   assign send_len = 4'h5 + {2'h0, send_length_select};
   assign send_bit = send_code_value[3'h7 - send_phase];
   assign overwrite = send_code_enable
                      & (send_unframed | ~tx_bit_fbit);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         send_phase <= 3'h0;
         tx_out_valid <= 1'b0;
         tx_out_fbit <= 1'b0;
         tx_out_bit <= 1'b0;
      end
      else
      begin
         tx_out_valid <= tx_bit_valid;
         if (tx_bit_valid)
         begin
            tx_out_fbit <= tx_bit_fbit;
            tx_out_bit <= overwrite ? send_bit : tx_bit_in;
         end
         // Phase restarts when disabled so the code opens with bit 7
         if (!send_code_enable)
            send_phase <= 3'h0;
         else if (tx_bit_valid && overwrite)
         begin
            if ({1'b0, send_phase} + 4'h1 >= send_len)
               send_phase <= 3'h0;
            else
               send_phase <= send_phase + 3'h1;
         end
      end
   end
endmodule // ilc_top

//--- design/ilc_defines.vh
`ifndef ILC_DEFINES_VH
`define ILC_DEFINES_VH

// Register indexes; byte address is four times the index
`define ILC_IDX_SEND_CTRL 10'h074
`define ILC_IDX_SEND_CODE 10'h075
`define ILC_IDX_DET_CFG 10'h076
`define ILC_IDX_DET_STATE 10'h077
`define ILC_IDX_UP_CODE 10'h078
`define ILC_IDX_DOWN_CODE 10'h079
`define ILC_IDX_IRQ_EN 10'h07A
`define ILC_IDX_IRQ_FLAGS 10'h07B

// Send control fields
`define ILC_SEND_LEN_LSB 0
`define ILC_SEND_UNFRAMED_BIT 2
`define ILC_SEND_ENABLE_BIT 3

// Detector configuration fields
`define ILC_UP_SEL_LSB 0
`define ILC_DOWN_SEL_LSB 2
`define ILC_FBIT_SKIP_BIT 4

// Status, enable and flag layout
`define ILC_DOWN_BIT 0
`define ILC_UP_BIT 1

// Reset values
`define ILC_RST_SEND_CTRL 8'h00
`define ILC_RST_SEND_CODE 8'h00
`define ILC_RST_DET_CFG 8'h04
`define ILC_RST_UP_CODE 8'h08
`define ILC_RST_DOWN_CODE 8'h24
`define ILC_RST_IRQ_EN 8'h00

// Timing
`define ILC_PCLK_PERIOD_PS 5000
`define ILC_MEAS_PERIOD_US 39800
// Split so the intermediate product stays inside 32 bits
`define ILC_MEAS_CYCLES (((`ILC_MEAS_PERIOD_US * 1000) / `ILC_PCLK_PERIOD_PS) * 1000)
`define ILC_ERR_LIMIT 600
`define ILC_GOOD_PERIODS 126

`endif

//--- design/ilc_matcher.v
module ilc_matcher #(
   parameter ERR_LIMIT = 600,
   parameter GOOD_PERIODS = 126
)(
   input wire pclk,
   input wire presetn,
   input wire bit_valid,
   input wire bit_value,
   input wire bit_is_fbit,
   input wire skip_fbit,
   input wire [7:0] code_bits,
   input wire [1:0] length_select,
   input wire period_end,
   output reg present
);
   localparam [9:0] ERR_MAX = 10'h3FF;
   localparam integer ERR_LIM_I = ERR_LIMIT;
   localparam integer GOOD_LIM_I = GOOD_PERIODS;
   localparam [9:0] ERR_LIM = ERR_LIM_I[9:0];
   localparam [7:0] GOOD_LIM = GOOD_LIM_I[7:0];

   wire [3:0] code_len;
   wire counted;
   wire step;
   wire [7:0] good_vec;
   wire [7:0] loss_vec;
   reg [2:0] phase;
   reg [7:0] streak;
   wire [7:0] next_streak;

   assign code_len = 4'h5 + {2'h0, length_select};
   // F-bit still steps the phase when compared, but its result is dropped
   assign step = bit_valid & ~(bit_is_fbit & skip_fbit);
   assign counted = bit_valid & ~bit_is_fbit;
   assign next_streak = (streak == 8'hFF) ? streak : streak + 8'h01;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         phase <= 3'h0;
      else if (step)
      begin
         if ({1'b0, phase} + 4'h1 >= code_len)
            phase <= 3'h0;
         else
            phase <= phase + 3'h1;
      end
   end

   // One error counter per alignment, so the code is found at any phase
   genvar j;
   generate
      for (j = 0; j < 8; j = j + 1)
      begin : g_align
         localparam integer JI = j;
         localparam [3:0] POS = JI[3:0];
         wire [3:0] raw;
         wire [3:0] idx;
         wire expected;
         wire used;
         reg [9:0] errs;
         assign raw = {1'b0, phase} + POS;
         assign idx = (raw >= code_len) ? raw - code_len : raw;
         assign expected = code_bits[3'h7 - idx[2:0]];
         assign used = (POS < code_len);
         assign good_vec[j] = used & (errs < ERR_LIM);
         assign loss_vec[j] = ~used | (errs > ERR_LIM);
         always @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
               errs <= 10'h000;
            else if (period_end)
               errs <= 10'h000;
            else if (counted && used && bit_value != expected
                     && errs != ERR_MAX)
               errs <= errs + 10'h001;
         end
      end
   endgenerate

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         present <= 1'b0;
         streak <= 8'h00;
      end
      else if (period_end)
      begin
         if (&loss_vec)
         begin
            present <= 1'b0;
            streak <= 8'h00;
         end
         else if (|good_vec)
         begin
            streak <= next_streak;
            if (next_streak > GOOD_LIM)
               present <= 1'b1;
         end
         else
            streak <= 8'h00;
      end
   end
endmodule // ilc_matcher

//--- dv/ilc_sva.sv
`include "ilc_defines.vh"
module ilc_sva #(
   parameter MEAS_CYCLES = 200
)(
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire tx_bit_valid,
   input wire tx_bit_fbit,
   input wire tx_bit_in,
   input wire tx_out_valid,
   input wire tx_out_fbit,
   input wire tx_out_bit,
   input wire irq
);
   timeunit 1ns;
   timeprecision 1ps;
   wire wr = psel && penable && pwrite && pready && paddr[1:0] == 2'h0;
   wire [9:0] idx = paddr[11:2];
   reg [3:0] ctl;
   reg [1:0] ien;
   integer pc;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctl <= 4'h0;
         ien <= 2'h0;
         pc <= 0;
      end
      else
      begin
         pc <= (pc == MEAS_CYCLES - 1) ? 0 : pc + 1;
         if (wr && idx == `ILC_IDX_SEND_CTRL)
            ctl <= pwdata[3:0];
         if (wr && idx == `ILC_IDX_IRQ_EN)
            ien <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_take;
      tx_bit_valid ##1 tx_out_valid;
   endsequence
   a_tx_answer: assert property (tx_bit_valid |-> s_take)
      else $error("tx bit lost");
   a_tx_quiet: assert property (!tx_bit_valid |=> !tx_out_valid)
      else $error("tx extra bit");
   a_tx_pass_off: assert property (tx_bit_valid && !ctl[3] |=>
      tx_out_bit == $past(tx_bit_in)) else $error("tx bit altered");
   a_fbit_kept: assert property (tx_bit_valid && tx_bit_fbit && !ctl[2] |=>
      tx_out_fbit && tx_out_bit == $past(tx_bit_in)) else $error("fbit lost");
   a_irq_masked: assert property (ien == 2'h0 |-> !irq)
      else $error("irq masked");
   a_irq_sticky: assert property (irq && !wr |=> irq)
      else $error("irq dropped");
   a_irq_off: assert property (wr && idx == `ILC_IDX_IRQ_EN &&
      pwdata[1:0] == 2'h0 |=> !irq) else $error("irq stays");
   a_irq_timing: assert property ($rose(irq) |-> pc < 6 ||
      $past(wr && idx == `ILC_IDX_IRQ_EN)) else $error("irq timing");
endmodule // ilc_sva
bind ilc_top ilc_sva #(.MEAS_CYCLES(MEAS_CYCLES)) u_sva (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .tx_bit_valid(tx_bit_valid), .tx_bit_fbit(tx_bit_fbit),
   .tx_bit_in(tx_bit_in), .tx_out_valid(tx_out_valid),
   .tx_out_fbit(tx_out_fbit), .tx_out_bit(tx_out_bit), .irq(irq));

//--- dv/ilc_far_end.sv
module ilc_far_end (
   input wire pclk,
   input wire presetn,
   input wire [7:0] code,
   input wire [3:0] len,
   input wire noise,
   input wire fskip,
   output logic rx_bit_valid,
   output logic rx_bit_fbit,
   output logic rx_bit_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] lfsr;
   int ph, pos;
   logic nb;
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_bit_valid <= 1'b0;
         rx_bit_fbit <= 1'b0;
         rx_bit_in <= 1'b0;
         lfsr <= 32'h00C0FFEE;
         ph <= 0;
         pos <= 0;
      end
      else if (!rx_bit_valid)
      begin
         nb = noise ? lfsr[0] : code[7 - ph];
         rx_bit_valid <= 1'b1;
         rx_bit_fbit <= pos == 0;
         // Without fskip the F-bit takes a code slot; either way it carries the wrong value
         rx_bit_in <= (pos == 0) ? ~nb : nb;
         // With fskip the F-bit carries no code bit, so the code phase holds
         ph <= (pos == 0 && fskip) ? ph : (ph >= len - 1) ? 0 : ph + 1;
         pos <= (pos == 192) ? 0 : pos + 1;
         lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      end
      else
      begin
         rx_bit_valid <= 1'b0;
         // Stale data between bits
         rx_bit_in <= ~rx_bit_in;
      end
   end
endmodule // ilc_far_end

//--- dv/tb_top.sv
`include "ilc_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MC = 200;
   localparam int GP = 2;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, err, tx_bit_valid = 1'b0, tx_bit_fbit = 1'b0;
   logic tx_bit_in = 1'b0, fe_noise = 1'b1, fe_skip = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, xs_state = 32'h0000004B;
   logic [7:0] fe_code = 8'h00;
   logic [3:0] fe_len = 4'h8;
   wire [31:0] prdata;
   wire pready, pslverr, tx_out_valid, tx_out_fbit, tx_out_bit, irq;
   wire rx_bit_valid, rx_bit_fbit, rx_bit_in;
   int n_mismatch = 0, checked = 0, cyc = 0;
   logic [9:0] ix [8] = '{`ILC_IDX_SEND_CTRL, `ILC_IDX_SEND_CODE,
      `ILC_IDX_DET_CFG, `ILC_IDX_DET_STATE, `ILC_IDX_UP_CODE,
      `ILC_IDX_DOWN_CODE, `ILC_IDX_IRQ_EN, `ILC_IDX_IRQ_FLAGS};
   logic [7:0] rv [8] = '{`ILC_RST_SEND_CTRL, `ILC_RST_SEND_CODE,
      `ILC_RST_DET_CFG, 8'h00, `ILC_RST_UP_CODE, `ILC_RST_DOWN_CODE,
      `ILC_RST_IRQ_EN, 8'h00};
   logic [7:0] rm [8] = '{8'h0F, 8'hFF, 8'h1F, 8'h00, 8'hFF, 8'hFF, 8'h03,
      8'h00};
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) cyc <= cyc + 1;
   ilc_top #(.MEAS_CYCLES(MC), .ERR_LIMIT(3), .GOOD_PERIODS(GP)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_bit_valid(tx_bit_valid),
      .tx_bit_fbit(tx_bit_fbit), .tx_bit_in(tx_bit_in),
      .tx_out_valid(tx_out_valid), .tx_out_fbit(tx_out_fbit),
      .tx_out_bit(tx_out_bit), .rx_bit_valid(rx_bit_valid),
      .rx_bit_fbit(rx_bit_fbit), .rx_bit_in(rx_bit_in), .irq(irq));
   ilc_far_end u_far (.pclk(pclk), .presetn(presetn), .code(fe_code),
      .len(fe_len), .noise(fe_noise), .fskip(fe_skip),
      .rx_bit_valid(rx_bit_valid),
      .rx_bit_fbit(rx_bit_fbit), .rx_bit_in(rx_bit_in));
   function logic [31:0] xs();
      xs_state ^= xs_state << 13;
      xs_state ^= xs_state >> 17;
      xs_state ^= xs_state << 5;
      return xs_state;
   endfunction
   function logic [11:0] ba(logic [9:0] i);
      return {i, 2'b00};
   endfunction
   task chk(string nm, logic [31:0] seen, logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(logic w, logic [11:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1)
         n_mismatch++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task tx_run(logic [7:0] c, int len, logic unf, logic en);
      int ph;
      logic fb, bi, e, pf;
      ph = 0;
      pf = 1'b0;
      for (int k = 0; k <= 20; k++)
      begin
         fb = xs() % 4 == 0;
         bi = xs() % 2;
         @(posedge pclk);
         tx_bit_valid <= k < 20;
         tx_bit_fbit <= fb;
         tx_bit_in <= bi;
         #1;
         if (k > 0)
         begin
            chk("tx bit", tx_out_bit, e);
            chk("tx fbit", tx_out_fbit, pf);
            chk("tx valid", tx_out_valid, 1);
         end
         pf = fb;
         if (!en || (fb && !unf))
            e = bi;
         else
         begin
            e = c[7 - ph];
            ph = (ph + 1) % len;
         end
      end
   endtask
   task wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < (GP + 4) * MC)
      begin
         @(posedge pclk);
         n++;
      end
      chk("irq up", irq, 1);
   endtask
   task results();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge pclk);
      n_mismatch++;
      results();
   end
   initial
   begin
      int i, t0;
      logic [31:0] c;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 8; i++)
      begin
         apb(1'b0, ba(ix[i]), 32'h0);
         chk("reset value", rd, {24'h0, rv[i]});
      end
      apb(1'b0, 12'h1F0, 32'h0);
      chk("unmapped", err, 1);
      apb(1'b0, 12'h1D1, 32'h0);
      chk("unaligned", err, 1);
      for (i = 0; i < 8; i++)
      begin
         c = xs();
         apb(1'b1, ba(ix[i]), c);
         apb(1'b0, ba(ix[i]), 32'h0);
         chk("readback", rd, c[7:0] & rm[i]);
      end
      $display("registers done");
      for (i = 0; i < 9; i++)
      begin
         c = xs();
         apb(1'b1, ba(`ILC_IDX_SEND_CTRL), 32'h0);
         apb(1'b1, ba(`ILC_IDX_SEND_CODE), c);
         apb(1'b1, ba(`ILC_IDX_SEND_CTRL), {28'h0, i < 8, i[2], i[1:0]});
         tx_run(c[7:0], 5 + i % 4, i[2], i < 8);
      end
      apb(1'b1, ba(`ILC_IDX_SEND_CTRL), 32'h0);
      $display("transmit done");
      // Unused low code bits differ from the line pattern on purpose
      apb(1'b1, ba(`ILC_IDX_UP_CODE), 32'hE1);
      apb(1'b1, ba(`ILC_IDX_DOWN_CODE), 32'h27);
      apb(1'b1, ba(`ILC_IDX_DET_CFG), 32'h06);
      apb(1'b1, ba(`ILC_IDX_IRQ_FLAGS), 32'h3);
      apb(1'b1, ba(`ILC_IDX_IRQ_EN), 32'h3);
      fe_code <= 8'hE0;
      fe_len <= 4'h7;
      fe_noise <= 1'b0;
      t0 = cyc;
      wait_irq();
      chk("up delay", cyc - t0 >= GP * MC, 1);
      apb(1'b0, ba(`ILC_IDX_DET_STATE), 32'h0);
      chk("up found", rd, 32'h2);
      apb(1'b0, ba(`ILC_IDX_IRQ_FLAGS), 32'h0);
      chk("up flag", rd, 32'h2);
      apb(1'b1, ba(`ILC_IDX_IRQ_FLAGS), 32'h2);
      #1 chk("irq clear", irq, 0);
      apb(1'b1, ba(`ILC_IDX_IRQ_EN), 32'h1);
      fe_noise <= 1'b1;
      repeat (3 * MC) @(posedge pclk);
      apb(1'b0, ba(`ILC_IDX_DET_STATE), 32'h0);
      chk("up lost", rd, 32'h0);
      apb(1'b0, ba(`ILC_IDX_IRQ_FLAGS), 32'h0);
      chk("up flag", rd, 32'h2);
      chk("irq masked", irq, 0);
      apb(1'b1, ba(`ILC_IDX_IRQ_EN), 32'h3);
      #1 chk("irq enabled", irq, 1);
      apb(1'b1, ba(`ILC_IDX_IRQ_FLAGS), 32'h3);
      // Down code is hunted with F-bits skipped to reach that mode
      apb(1'b1, ba(`ILC_IDX_DET_CFG), 32'h16);
      fe_skip <= 1'b1;
      fe_code <= 8'h24;
      fe_len <= 4'h6;
      fe_noise <= 1'b0;
      wait_irq();
      apb(1'b0, ba(`ILC_IDX_DET_STATE), 32'h0);
      chk("down found", rd, 32'h1);
      apb(1'b0, ba(`ILC_IDX_IRQ_FLAGS), 32'h0);
      chk("down flag", rd, 32'h1);
      apb(1'b1, ba(`ILC_IDX_IRQ_EN), 32'h2);
      #1 chk("irq masked", irq, 0);
      apb(1'b1, ba(`ILC_IDX_IRQ_FLAGS), 32'h1);
      fe_noise <= 1'b1;
      repeat (3 * MC) @(posedge pclk);
      apb(1'b0, ba(`ILC_IDX_DET_STATE), 32'h0);
      chk("down lost", rd, 32'h0);
      apb(1'b1, ba(`ILC_IDX_IRQ_EN), 32'h3);
      #1 chk("irq enabled", irq, 1);
      apb(1'b1, ba(`ILC_IDX_IRQ_EN), 32'h0);
      #1 chk("irq off", irq, 0);
      $display("detector done");
      results();
   end
endmodule // tb_top
